// File: core/swc_regs.sv
// switch-input high-impedance and wetting-current level register bank behind a serial port
// Contract
// - ground tri-state register 0x03, fourteen enables, default one
// - every programmable input and ground inputs 7..0 level configurable, reset selects 16 mA
// - one contiguous 3-bit level field per input
// - level writes accepted anytime in Normal mode
// - programmable level register 0x04, eight fields, 110
// - ground level register 0x05, inputs 7..0, 110
// - tri-stated input high impedance, comparator stays active
// - level codes decode 2,6,8,10,12,14,16,20 mA
`timescale 1ns/1ps
`default_nettype none
`include "swc_cfg.svh"
module swc_regs #(
  parameter int N_PROG = 8, // programmable inputs with a level field
  parameter int N_GLVL = 8, // ground inputs with a level field here
  parameter int N_GROUND = 14 // ground inputs with a tri-state bit
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_sclk, // serial clock from the host
  input wire logic i_cs_n, // frame select, active low
  input wire logic i_mosi, // serial data from the host
  input wire logic i_normal_mode, // high while the device is in Normal mode
  output logic o_miso, // serial response data
  output logic o_miso_oe, // response pin enable
  output logic [N_GROUND-1:0] o_ground_high_z, // tri-state enables
  output logic [N_GROUND-1:0] o_ground_source_en, // current source allowed
  output logic [N_GROUND-1:0] o_ground_comp_en, // threshold comparator enabled
  output logic [3*N_PROG-1:0] o_prog_level, // raw level codes
  output logic [3*N_GLVL-1:0] o_ground_level, // raw level codes
  output logic [8*N_PROG-1:0] o_prog_current_dma, // decoded currents, 0.1 mA
  output logic [8*N_GLVL-1:0] o_ground_current_dma // decoded, zero when tri-stated
);
  import swc_pkg::*;

  // ==========================================================
  // parameter checks
  // fields must fit the 24-bit data word
  // a bad value stops elaboration rather than silently losing fields
  if (N_PROG < 1 || `SWC_FIELD_W * N_PROG > `SWC_DATA_W) begin : g_bad_prog
    $error("N_PROG out of range");
  end
  // every ground input with a level field also needs its tri-state bit
  if (N_GLVL < 1 || `SWC_FIELD_W * N_GLVL > `SWC_DATA_W || N_GLVL > N_GROUND) begin : g_bad_glvl
    $error("N_GLVL out of range");
  end
  if (N_GROUND < 1 || N_GROUND > `SWC_DATA_W) begin : g_bad_ground
    $error("N_GROUND out of range");
  end

  // ==========================================================
  // frame engine
  swc_if link ();

  swc_spi_slave u_spi (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_mosi(i_mosi),
    .o_miso(o_miso),
    .o_miso_oe(o_miso_oe),
    .bus(link.slave)
  );

  // ==========================================================
  // decode functions
  // address to register select, used for read and write
  function automatic swc_sel_type addr_sel(input logic [6:0] a);
    swc_sel_type s;
    s = SWC_SEL_NONE;
    unique case (a)
      `SWC_ADDR_HIGH_Z: s = SWC_SEL_HIGH_Z;
      `SWC_ADDR_PROG_LEVEL: s = SWC_SEL_PROG_LEVEL;
      `SWC_ADDR_GROUND_LEVEL: s = SWC_SEL_GROUND_LEVEL;
      default: s = SWC_SEL_NONE; // other addresses belong elsewhere
    endcase
    return s;
  endfunction : addr_sel

  // level code to current, in 0.1 mA steps
  function automatic logic [7:0] level_dma(input swc_level_type c);
    logic [7:0] v;
    v = `SWC_DMA_OFF;
    unique case (c)
      3'h0: v = `SWC_DMA_CODE0;
      3'h1: v = `SWC_DMA_CODE1;
      3'h2: v = `SWC_DMA_CODE2;
      3'h3: v = `SWC_DMA_CODE3;
      3'h4: v = `SWC_DMA_CODE4;
      3'h5: v = `SWC_DMA_CODE5;
      3'h6: v = `SWC_DMA_CODE6;
      3'h7: v = `SWC_DMA_CODE7;
    endcase
    return v;
  endfunction : level_dma

  // ==========================================================
  // configuration registers
  logic [N_GROUND-1:0] ground_input_high_impedance; // high-impedance enables
  logic [N_GROUND-1:0] next_ground_input_high_impedance;
  logic [`SWC_FIELD_W*N_PROG-1:0] programmable_input_current_level; // programmable input levels
  logic [`SWC_FIELD_W*N_PROG-1:0] next_programmable_input_current_level;
  logic [`SWC_FIELD_W*N_GLVL-1:0] ground_input_current_level_low; // ground input levels 7..0
  logic [`SWC_FIELD_W*N_GLVL-1:0] next_ground_input_current_level_low;
  swc_sel_type wsel; // register addressed by the finished frame
  logic wr_ok; // a write frame is accepted this cycle

  // write path: complete write frames only, and only in Normal mode
  // a write outside Normal mode is dropped rather than deferred, so a
  // mode change never applies stale settings later
  always_comb begin
    wsel = addr_sel(link.addr);
    wr_ok = link.frame_valid & link.write & i_normal_mode;
    next_ground_input_high_impedance = ground_input_high_impedance;
    next_programmable_input_current_level = programmable_input_current_level;
    next_ground_input_current_level_low = ground_input_current_level_low;
    if (wr_ok) begin
      unique case (wsel)
        SWC_SEL_HIGH_Z: begin
          // unused upper data bits are not stored, so they always read zero
          next_ground_input_high_impedance = link.wdata[N_GROUND-1:0];
        end
        SWC_SEL_PROG_LEVEL: begin
          next_programmable_input_current_level = link.wdata[`SWC_FIELD_W*N_PROG-1:0];
        end
        SWC_SEL_GROUND_LEVEL: begin
          next_ground_input_current_level_low = link.wdata[`SWC_FIELD_W*N_GLVL-1:0];
        end
        SWC_SEL_NONE: begin
          // unmapped here: ignored
        end
      endcase
    end
  end

  // register the configuration; reset loads the power-on defaults
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ground_input_high_impedance <= {N_GROUND{`SWC_TRI_RESET_BIT}};
      programmable_input_current_level <= {N_PROG{`SWC_LVL_RESET}};
      ground_input_current_level_low <= {N_GLVL{`SWC_LVL_RESET}};
    end else begin
      ground_input_high_impedance <= next_ground_input_high_impedance;
      programmable_input_current_level <= next_programmable_input_current_level;
      ground_input_current_level_low <= next_ground_input_current_level_low;
    end
  end

  // ==========================================================
  // read path
  // contents of the addressed register, unused bits read zero
  // the frame engine samples this once per frame, before the frame's own write
  always_comb begin
    link.rdata = '0;
    unique case (addr_sel(link.addr))
      SWC_SEL_HIGH_Z: begin
        link.rdata[N_GROUND-1:0] = ground_input_high_impedance;
      end
      SWC_SEL_PROG_LEVEL: begin
        link.rdata[`SWC_FIELD_W*N_PROG-1:0] = programmable_input_current_level;
      end
      SWC_SEL_GROUND_LEVEL: begin
        link.rdata[`SWC_FIELD_W*N_GLVL-1:0] = ground_input_current_level_low;
      end
      SWC_SEL_NONE: begin
        link.rdata = '0; // unmapped address answers zero
      end
    endcase
  end

  // ==========================================================
  // decoded drive settings
  logic [8*N_PROG-1:0] prog_dma, next_prog_dma; // programmable currents
  logic [8*N_GLVL-1:0] gnd_dma, next_gnd_dma; // ground currents
  logic [N_GROUND-1:0] src_en, next_src_en; // source allowed per input

  // decode every field; a tri-stated input gets no current whatever
  // its level code says, but its comparator is left running
  always_comb begin
    next_prog_dma = '0;
    next_gnd_dma = '0;
    next_src_en = ~ground_input_high_impedance;
    for (int i = 0; i < N_PROG; i++) begin
      next_prog_dma[`SWC_DMA_W*i +: `SWC_DMA_W] =
        level_dma(programmable_input_current_level[`SWC_FIELD_W*i +: `SWC_FIELD_W]);
    end
    for (int j = 0; j < N_GLVL; j++) begin
      if (ground_input_high_impedance[j]) begin
        next_gnd_dma[`SWC_DMA_W*j +: `SWC_DMA_W] = `SWC_DMA_OFF;
      end else begin
        next_gnd_dma[`SWC_DMA_W*j +: `SWC_DMA_W] =
          level_dma(ground_input_current_level_low[`SWC_FIELD_W*j +: `SWC_FIELD_W]);
      end
    end
  end

  // register the decoded settings so the outputs are glitch free;
  // costs one cycle of latency after a write lands
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      prog_dma <= {N_PROG{`SWC_DMA_CODE6}};
      gnd_dma <= '0;
      src_en <= '0;
    end else begin
      prog_dma <= next_prog_dma;
      gnd_dma <= next_gnd_dma;
      src_en <= next_src_en;
    end
  end

  // ==========================================================
  // outputs
  assign o_ground_high_z = ground_input_high_impedance;
  assign o_ground_source_en = src_en;
  assign o_ground_comp_en = {N_GROUND{1'b1}};
  assign o_prog_level = programmable_input_current_level;
  assign o_ground_level = ground_input_current_level_low;
  assign o_prog_current_dma = prog_dma;
  assign o_ground_current_dma = gnd_dma;

endmodule : swc_regs
`default_nettype wire

// File: inc/swc_cfg.svh
// register addresses, reset values, field positions and level codes of the switch-input config bank
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH
// register addresses (7-bit frame address field)
`define SWC_ADDR_HIGH_Z 7'h03
`define SWC_ADDR_PROG_LEVEL 7'h04
`define SWC_ADDR_GROUND_LEVEL 7'h05
// reset values
`define SWC_TRI_RESET_BIT 1'h1
`define SWC_LVL_RESET 3'h6
// frame layout
`define SWC_FRAME_BITS 6'h20
`define SWC_ADDR_DONE_CNT 6'h07
`define SWC_RESP_START_CNT 6'h08
`define SWC_CNT_MAX 6'h3f
`define SWC_ADDR_MSB 31
`define SWC_ADDR_LSB 25
`define SWC_RW_BIT 24
`define SWC_EARLY_ADDR_MSB 7
`define SWC_EARLY_ADDR_LSB 1
`define SWC_DATA_W 24
`define SWC_FIELD_W 3
`define SWC_DMA_W 8
// wetting current per level code, in units of 0.1 mA
`define SWC_DMA_CODE0 8'h14
`define SWC_DMA_CODE1 8'h3c
`define SWC_DMA_CODE2 8'h50
`define SWC_DMA_CODE3 8'h64
`define SWC_DMA_CODE4 8'h78
`define SWC_DMA_CODE5 8'h8c
`define SWC_DMA_CODE6 8'ha0
`define SWC_DMA_CODE7 8'hc8
`define SWC_DMA_OFF 8'h00
`endif

// File: inc/swc_pkg.sv
// types shared by the switch-input config bank
`default_nettype none
package swc_pkg;
  // which register a frame address selects
  typedef enum logic [1:0] {
    SWC_SEL_NONE,
    SWC_SEL_HIGH_Z,
    SWC_SEL_PROG_LEVEL,
    SWC_SEL_GROUND_LEVEL
  } swc_sel_type;
  // one 3-bit wetting level code
  typedef logic [2:0] swc_level_type;
endpackage : swc_pkg
`default_nettype wire

// File: inc/swc_if.sv
// link between the serial frame engine and the register bank
`timescale 1ns/1ps
`default_nettype none
interface swc_if;
  logic addr_valid; // one-cycle pulse: address of the running frame known
  logic [6:0] addr; // frame address field
  logic [23:0] rdata; // contents of the addressed register
  logic frame_valid; // one-cycle pulse: complete 32-bit frame received
  logic write; // read/write flag of the finished frame, 1 = write
  logic [23:0] wdata; // data field of the finished frame
  modport slave (output addr_valid, output addr, output frame_valid, output write, output wdata, input rdata);
  modport regs (input addr_valid, input addr, input frame_valid, input write, input wdata, output rdata);
endinterface : swc_if
`default_nettype wire

// File: core/swc_spi_slave.sv
// serial frame engine: 32-bit frames in, register contents out on the response line
`timescale 1ns/1ps
`default_nettype none
`include "swc_cfg.svh"
module swc_spi_slave (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  swc_if.slave bus
);
  import swc_pkg::*;
  // ==========================================================
  // state
  logic sclk_q, next_sclk_q; // last sclk sample, for edge finding
  logic cs_q, next_cs_q; // last select sample
  logic [5:0] cnt, next_cnt; // rising edges seen in this frame
  logic [31:0] shin, next_shin; // receive shifter, msb first
  logic [23:0] shout, next_shout; // response shifter
  logic miso_q, next_miso_q; // response bit on the pin
  logic apulse, next_apulse; // address-known pulse
  logic rise, fall, cs_end;
  // ==========================================================
  // next-state logic; sclk must stay at most mclk/4
  always_comb begin
    rise = i_sclk & ~sclk_q;
    fall = ~i_sclk & sclk_q;
    cs_end = i_cs_n & ~cs_q;
    next_sclk_q = i_sclk;
    next_cs_q = i_cs_n;
    next_cnt = cnt;
    next_shin = shin;
    next_shout = shout;
    next_miso_q = miso_q;
    next_apulse = 1'b0;
    if (i_cs_n) begin
      // deselected: restart the frame count, response line low
      next_cnt = '0;
      next_miso_q = 1'b0;
    end else if (rise) begin
      // sample on sclk rising, mode 0
      next_shin = {shin[30:0], i_mosi};
      if (cnt != `SWC_CNT_MAX) begin
        next_cnt = cnt + 6'h01;
      end
      next_apulse = (cnt == `SWC_ADDR_DONE_CNT);
    end else if (fall && cnt >= `SWC_RESP_START_CNT) begin
      // drive next response bit on sclk falling
      next_miso_q = shout[23];
      next_shout = {shout[22:0], 1'b0};
    end
    if (apulse) begin
      next_shout = bus.rdata;
    end
  end
  // ==========================================================
  // registers
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      cnt <= '0;
      shin <= '0;
      shout <= '0;
      miso_q <= 1'b0;
      apulse <= 1'b0;
    end else begin
      sclk_q <= next_sclk_q;
      cs_q <= next_cs_q;
      cnt <= next_cnt;
      shin <= next_shin;
      shout <= next_shout;
      miso_q <= next_miso_q;
      apulse <= next_apulse;
    end
  end
  // ==========================================================
  // outputs; frames of any length but 32 are dropped
  assign bus.addr_valid = apulse;
  assign bus.addr = apulse ? shin[`SWC_EARLY_ADDR_MSB:`SWC_EARLY_ADDR_LSB] : shin[`SWC_ADDR_MSB:`SWC_ADDR_LSB];
  assign bus.frame_valid = cs_end & (cnt == `SWC_FRAME_BITS);
  assign bus.write = shin[`SWC_RW_BIT];
  assign bus.wdata = shin[`SWC_DATA_W-1:0];
  assign o_miso = miso_q;
  assign o_miso_oe = ~i_cs_n;
endmodule : swc_spi_slave
`default_nettype wire

// File: verification/swc_regs_asserts.sv
// port-level assertions for the switch-input config bank
`timescale 1ns/1ps
`default_nettype none
module swc_regs_asserts #(
  parameter int N_PROG = 8,
  parameter int N_GLVL = 8,
  parameter int N_GROUND = 14
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_cs_n,
  input wire logic o_miso,
  input wire logic o_miso_oe,
  input wire logic [N_GROUND-1:0] o_ground_high_z,
  input wire logic [N_GROUND-1:0] o_ground_source_en,
  input wire logic [N_GROUND-1:0] o_ground_comp_en,
  input wire logic [3*N_PROG-1:0] o_prog_level,
  input wire logic [3*N_GLVL-1:0] o_ground_level,
  input wire logic [8*N_PROG-1:0] o_prog_current_dma,
  input wire logic [8*N_GLVL-1:0] o_ground_current_dma
);
  // ==========
  // helpers
  // ==========
  // level code to current in 0.1 mA, kept apart from the design's own table
  localparam logic [7:0] lvl_dma [8] = '{8'h14, 8'h3c, 8'h50, 8'h64, 8'h78, 8'h8c, 8'ha0, 8'hc8};
  logic [3:0] hi_cnt; // cycles since select went high, saturates
  // counter lets the write window be bounded without a long repetition
  // select low restarts the count even from saturation, so every frame end is seen
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      hi_cnt <= 4'hf;
    end else if (!i_cs_n) begin
      hi_cnt <= 4'h0;
    end else if (hi_cnt != 4'hf) begin
      hi_cnt <= hi_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // ==========
  // assertions
  // ==========
  a_oe_tracks_cs: assert property (o_miso_oe == !i_cs_n) else $error("pin enable wrong");
  a_miso_idle: assert property (i_cs_n && $past(i_cs_n) |-> !o_miso) else $error("miso not idle");
  a_reset_vals: assert property ($past(i_reset) |-> o_ground_high_z == '1 && o_prog_level == 24'hdb6db6
    && o_ground_level == 24'hdb6db6) else $error("bad reset value");
  a_source_off: assert property (o_ground_source_en == ~$past(o_ground_high_z)) else $error("source on");
  a_comp_on: assert property (&o_ground_comp_en) else $error("comparator off");
  a_prog_decode: assert property (o_prog_current_dma[7:0] == lvl_dma[$past(o_prog_level[2:0])])
    else $error("prog decode");
  a_gnd_decode: assert property (o_ground_current_dma[63:56] == ($past(o_ground_high_z[7]) ? 8'h00
    : lvl_dma[$past(o_ground_level[23:21])])) else $error("ground decode");
  a_write_window: assert property (!$stable({o_ground_high_z, o_prog_level, o_ground_level})
    |-> hi_cnt inside {[4'h1:4'h4]}) else $error("change outside frame end");
  c_level_write: cover property (!$stable(o_prog_level));
  c_unclamp: cover property ($fell(o_ground_high_z[0]));
  c_frame_end: cover property ($rose(i_cs_n));
endmodule : swc_regs_asserts
bind swc_regs swc_regs_asserts #(.N_PROG(N_PROG), .N_GLVL(N_GLVL), .N_GROUND(N_GROUND)) u_swc_regs_asserts (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_cs_n(i_cs_n), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
  .o_ground_high_z(o_ground_high_z), .o_ground_source_en(o_ground_source_en),
  .o_ground_comp_en(o_ground_comp_en), .o_prog_level(o_prog_level), .o_ground_level(o_ground_level),
  .o_prog_current_dma(o_prog_current_dma), .o_ground_current_dma(o_ground_current_dma));
`default_nettype wire

// File: verification/swc_host.sv
// host-side serial master model, mode 0, msb first
`timescale 1ns/1ps
`default_nettype none
module swc_host (
  input wire logic i_mclk,
  input wire logic i_miso,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi
);
  // ==========
  // idle levels
  // ==========
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // one 32-bit frame; each clock phase spans 4 mclk so the design's sampler sees it
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_mclk);
    for (int i = 31; i >= 0; i--) begin
      o_mosi = tx[i];
      repeat (4) @(negedge i_mclk);
      rx[i] = i_miso;
      o_sclk = 1'b1;
      repeat (4) @(negedge i_mclk);
      o_sclk = 1'b0;
    end
    repeat (4) @(negedge i_mclk);
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // released line shows no stale data
    repeat (4) @(negedge i_mclk);
  endtask : xfer
  // a frame of nb bits, cut short or run long; the bank must drop it whole
  task automatic xfer_cut(input logic [39:0] tx, input int nb);
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_mclk);
    for (int i = 0; i < nb; i++) begin
      o_mosi = tx[39-i];
      repeat (4) @(negedge i_mclk);
      o_sclk = 1'b1;
      repeat (4) @(negedge i_mclk);
      o_sclk = 1'b0;
    end
    repeat (4) @(negedge i_mclk);
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // released line shows no stale data
    repeat (4) @(negedge i_mclk);
  endtask : xfer_cut
endmodule : swc_host
`default_nettype wire

// File: verification/swc_regs_tb.sv
// self-checking bench for the switch-input config bank
`timescale 1ns/1ps
`default_nettype none
module swc_regs_tb;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic i_normal_mode = 1'b1; // writes allowed
  logic sclk, cs_n, mosi, miso, miso_oe;
  logic [13:0] hz, src, comp;
  logic [23:0] plv, glv;
  logic [63:0] pdma, gdma;
  int err_count = 0;
  int tests_run = 0;
  always #5 i_mclk = ~i_mclk;
  swc_regs u_swc_regs (.i_mclk(i_mclk), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
    .i_normal_mode(i_normal_mode), .o_miso(miso), .o_miso_oe(miso_oe), .o_ground_high_z(hz),
    .o_ground_source_en(src), .o_ground_comp_en(comp), .o_prog_level(plv), .o_ground_level(glv),
    .o_prog_current_dma(pdma), .o_ground_current_dma(gdma));
  swc_host u_swc_host (.i_mclk(i_mclk), .i_miso(miso), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
  // ==========
  // helpers
  // ==========
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    logic [31:0] r;
    u_swc_host.xfer({a, 1'b1, d}, r);
  endtask : wr
  // reply carries a zero status byte, then the register
  task automatic rd(input logic [6:0] a, input logic [23:0] e);
    logic [31:0] r;
    u_swc_host.xfer({a, 1'b0, 24'h000000}, r);
    chk({32'h0, r}, {40'h0, e});
  endtask : rd
  // ==========
  // scenarios
  // ==========
  task automatic t_defaults;
    rd(7'h03, 24'h003fff);
    rd(7'h04, 24'hdb6db6);
    rd(7'h05, 24'hdb6db6);
    chk({50'h0, hz}, 64'h3fff);
    chk(pdma, {8{8'ha0}});
    chk(gdma, 64'h0);
  endtask : t_defaults
  // unused upper bits are written as ones and must read back zero
  task automatic t_tristate;
    wr(7'h03, 24'hffc000);
    rd(7'h03, 24'h000000);
    chk({50'h0, hz}, 64'h0000);
    chk({50'h0, src}, 64'h3fff);
    chk({50'h0, comp}, 64'h3fff);
  endtask : t_tristate
  // every code once per register, then clamp ground inputs 0, 2, 4 and 6
  task automatic t_levels;
    wr(7'h04, 24'hfac688);
    rd(7'h04, 24'hfac688);
    chk({40'h0, plv}, 64'hfac688);
    chk(pdma, 64'hc8a08c7864503c14);
    wr(7'h05, 24'h053977);
    rd(7'h05, 24'h053977);
    chk(gdma, 64'h143c5064788ca0c8);
    wr(7'h03, 24'h000055);
    chk({50'h0, hz}, 64'h0055);
    chk(gdma, 64'h140050007800a000);
  endtask : t_levels
  // write outside normal mode and to an unmapped place
  task automatic t_refused;
    i_normal_mode = 1'b0;
    wr(7'h04, 24'h000000);
    i_normal_mode = 1'b1;
    rd(7'h04, 24'hfac688);
    wr(7'h06, 24'hffffff);
    rd(7'h06, 24'h000000);
    // frames of 31 and 33 bits must leave the register untouched
    u_swc_host.xfer_cut({7'h04, 1'b1, 24'h000000, 8'h00}, 31);
    u_swc_host.xfer_cut({7'h04, 1'b1, 24'h000000, 8'h00}, 33);
    rd(7'h04, 24'hfac688);
    chk({40'h0, glv}, 64'h053977);
  endtask : t_refused
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  // ==========
  // main sequence, then a second reset mid-run
  // ==========
  initial begin
    repeat (20) @(negedge i_mclk);
    i_reset = 1'b0;
    @(negedge i_mclk);
    t_defaults();
    t_tristate();
    t_levels();
    t_refused();
    i_reset = 1'b1;
    repeat (20) @(negedge i_mclk);
    i_reset = 1'b0;
    @(negedge i_mclk);
    t_defaults();
    conclude();
  end
  // about 20 frames of 270 cycles each; allow nearly four times that
  initial begin
    #200000;
    err_count++;
    conclude();
  end
endmodule : swc_regs_tb
`default_nettype wire
